/* File: design/sls_supervisor.v */
// Limited-speed supervisor with trip-limit emergency stop and boot hold-off
// Functional notes
// - Request above trip limit starts the limited-speed time delay counter.
// - Disabled mode: modulation loss switches off time-delay monitoring.
// - Disabled mode waits for zero-speed delay expiry or modulation return.
// - Monitoring and indication start when speed falls to limit/trip midpoint.
// - Monitoring starts at the latest when the time delay has elapsed.
// - Modulation back after delay expiry with speed above trip gives limit hit.
// - At boot, assume very high speed until valid speed data exists.
// - Request active at reboot in monitor/modoff mode blocks restart until acknowledged after the delay.
// - Reboot starts the zero-speed delay counter.
// - Zero-speed delay expiry after boot allows acknowledge and sets indication.
// - Early torque-off acknowledge is refused and restarts zero-speed counter.
// - Speed above trip limit activates the emergency stop function.
// - Request below limit starts monitoring at once with indication.
// - Speed reaching trip limit clears the limited-speed indication.
// - After response time, emergency stop opens torque-off so motor coasts.
// - After zero-speed delay, completion indication and limited-speed indication set.
// - With brake control configured, brake delay times completion instead.
// - Removing request keeps monitoring until acknowledged.
// - One acknowledge stops monitoring, acknowledges emergency stop, clears indications.
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`default_nettype none
`include "sls_regs.vh"
module sls_supervisor (
	input  wire        i_core_clk,
	input  wire        i_rst,
	input  wire [7:0]  i_addr,
	input  wire [31:0] i_wdata,
	input  wire        i_wr,
	input  wire        i_rd,
	input  wire        i_request,
	input  wire        i_ack,
	input  wire        i_modulating,
	input  wire [15:0] i_speed,
	input  wire        i_speed_valid,
	output reg  [31:0] o_rdata,
	output reg         o_torque_off,
	output reg         o_restart_block,
	output reg         o_limited_speed_indication,
	output reg         o_estop_active,
	output reg         o_estop_done,
	output reg         o_limit_hit,
	output reg         o_ack_refused
);
	// States of the supervisor
	localparam [2:0] ST_BOOT    = 3'h0;
	localparam [2:0] ST_IDLE    = 3'h1;
	localparam [2:0] ST_DECEL   = 3'h2;
	localparam [2:0] ST_MODLOSS = 3'h3;
	localparam [2:0] ST_MONITOR = 3'h4;
	localparam [2:0] ST_RESPOND = 3'h5;
	localparam [2:0] ST_STOPPING = 3'h6;
	localparam [2:0] ST_STOPPED = 3'h7;

	// Counter expiry test shared by all delays
	function expired;
		input [31:0] cnt;
		input [31:0] lim;
		begin
			expired = (cnt >= lim);
		end
	endfunction

	// Configuration registers
	reg [3:0]  ctrl_reg;
	reg [15:0] trip_reg;
	reg [15:0] limit_reg;
	reg [31:0] tdelay_reg;
	reg [31:0] zdelay_reg;
	reg [31:0] bdelay_reg;
	reg [31:0] resp_reg;

	// Pin synchronisers: three stages, change accepted when 2nd and 3rd agree
	reg [2:0] req_sync_reg;
	reg [2:0] ack_sync_reg;
	reg [2:0] mod_sync_reg;
	reg       req_reg;
	reg       ack_reg;
	reg       ack_prev_reg;
	reg       mod_reg;
	always @(posedge i_core_clk) begin
		if (i_rst) begin
			req_sync_reg <= 3'h0;
			ack_sync_reg <= 3'h0;
			mod_sync_reg <= 3'h0;
			req_reg      <= 1'b0;
			ack_reg      <= 1'b0;
			ack_prev_reg <= 1'b0;
			mod_reg      <= 1'b0;
		end else begin
			req_sync_reg <= {req_sync_reg[1:0], i_request};
			ack_sync_reg <= {ack_sync_reg[1:0], i_ack};
			mod_sync_reg <= {mod_sync_reg[1:0], i_modulating};
			if (req_sync_reg[1] == req_sync_reg[2])
				req_reg <= req_sync_reg[2];
			if (ack_sync_reg[1] == ack_sync_reg[2])
				ack_reg <= ack_sync_reg[2];
			if (mod_sync_reg[1] == mod_sync_reg[2])
				mod_reg <= mod_sync_reg[2];
			ack_prev_reg <= ack_reg;
		end
	end
	// Rising edge of the settled acknowledge; both flops reset low like the idle pin
	wire ack_pulse = ack_reg & ~ack_prev_reg;

	// Speed held high until valid data arrives, so boot never looks safe
	reg [15:0] speed_reg;
	always @(posedge i_core_clk) begin
		if (i_rst)
			speed_reg <= `SLS_SPEED_INIT;
		else if (i_speed_valid)
			speed_reg <= i_speed;
		else if (!ctrl_reg[`SLS_CTRL_EST])
			speed_reg <= i_speed;
	end

	// Midpoint of limit and trip, widened to keep the carry
	wire [16:0] mid_sum   = {1'b0, limit_reg} + {1'b0, trip_reg};
	wire [15:0] midpoint  = mid_sum[16:1];
	wire        above_trip = (speed_reg > trip_reg);
	wire        at_trip    = (speed_reg >= trip_reg);

	// State and counters
	reg [2:0]  state_reg;
	reg [2:0]  state_next;
	reg [1:0]  mode_reg;
	reg        brake_reg;
	reg [31:0] tcnt_reg;
	reg        tmon_reg;
	reg [31:0] zcnt_reg;
	reg [31:0] rcnt_reg;
	reg        boot_hold_reg;
	// Boot waits for the pin synchronisers before judging the request pin,
	// otherwise a request held across reset would read as absent
	reg [2:0]  settle_reg;

	// Expiry flags; the stop timer follows the brake delay when brake control is on
	wire       t_done   = tmon_reg & expired(tcnt_reg, tdelay_reg);
	wire [31:0] stop_lim = brake_reg ? bdelay_reg : zdelay_reg;
	wire       z_done   = expired(zcnt_reg, stop_lim);

	// Next-state decision
	always @* begin
		state_next = state_reg;
		case (state_reg)
			// Leave boot once no hold applies, or the stop time ran out and was acknowledged
			ST_BOOT: begin
				if (!boot_hold_reg)
					state_next = ST_IDLE;
				else if (z_done && ack_pulse)
					state_next = ST_IDLE;
			end
			ST_IDLE: begin
				if (req_reg && at_trip)
					state_next = ST_DECEL;
				else if (req_reg)
					state_next = ST_MONITOR;
			end
			ST_DECEL: begin
				if (!mod_reg)
					state_next = ST_MODLOSS;
				else if (t_done && above_trip)
					state_next = ST_RESPOND;
				else if (speed_reg <= midpoint || t_done)
					state_next = ST_MONITOR;
			end
			// Monitor and modoff modes fall through to the time-delay trip
			ST_MODLOSS: begin
				if (mod_reg && t_done && above_trip)
					state_next = ST_RESPOND;
				else if (mod_reg)
					state_next = ST_DECEL;
				else if (z_done && mode_reg == `SLS_MODE_DISABLED)
					state_next = ST_MONITOR;
				else if (t_done && above_trip)
					state_next = ST_RESPOND;
				else if (z_done)
					state_next = ST_MONITOR;
			end
			ST_MONITOR: begin
				if (above_trip)
					state_next = ST_RESPOND;
				else if (ack_pulse && !req_reg)
					state_next = ST_IDLE;
			end
			ST_RESPOND: begin
				if (expired(rcnt_reg, resp_reg))
					state_next = ST_STOPPING;
			end
			ST_STOPPING: begin
				if (z_done)
					state_next = ST_STOPPED;
			end
			ST_STOPPED: begin
				if (ack_pulse)
					state_next = ST_IDLE;
			end
			default: state_next = ST_IDLE;
		endcase
	end

	// State, counters and outputs
	always @(posedge i_core_clk) begin
		if (i_rst) begin
			state_reg     <= ST_BOOT;
			mode_reg      <= `SLS_MODE_MONITOR;
			brake_reg     <= 1'b0;
			tcnt_reg      <= 32'h0;
			tmon_reg      <= 1'b0;
			zcnt_reg      <= 32'h0;
			rcnt_reg      <= 32'h0;
			boot_hold_reg <= 1'b1;
			settle_reg    <= 3'h0;
			o_torque_off  <= 1'b0;
			o_restart_block <= 1'b0;
			o_limited_speed_indication <= 1'b0;
			o_estop_active <= 1'b0;
			o_estop_done  <= 1'b0;
			o_limit_hit   <= 1'b0;
			o_ack_refused <= 1'b0;
		end else begin
			state_reg   <= state_next;
			o_limit_hit <= 1'b0;
			o_ack_refused <= 1'b0;
			// Boot: hold off restart only for request in monitor/modoff mode.
			// The decision waits until the synchronisers carry the real pin level.
			if (state_reg == ST_BOOT) begin
				if (settle_reg != `SLS_SYNC_SETTLE)
					settle_reg <= settle_reg + 3'h1;
				else
					boot_hold_reg <= req_reg & (ctrl_reg[`SLS_CTRL_MODE_HI:`SLS_CTRL_MODE_LO] != `SLS_MODE_DISABLED);
				o_restart_block <= boot_hold_reg & req_reg;
				// An early acknowledge is refused and the stop time starts over,
				// so a hurried operator cannot shorten the hold-off
				if (ack_pulse && !z_done) begin
					zcnt_reg      <= 32'h0;
					o_ack_refused <= 1'b1;
				end else if (!z_done)
					zcnt_reg <= zcnt_reg + 32'h1;
				// Expiry alone raises the indication; the acknowledge then frees restart
				if (boot_hold_reg && z_done)
					o_limited_speed_indication <= 1'b1;
				if (state_next == ST_IDLE && boot_hold_reg)
					o_restart_block <= 1'b0;
			end
			// Sample the selector as each request is taken
			if (state_reg == ST_IDLE && req_reg) begin
				mode_reg  <= ctrl_reg[`SLS_CTRL_MODE_HI:`SLS_CTRL_MODE_LO];
				brake_reg <= ctrl_reg[`SLS_CTRL_BRAKE];
				tcnt_reg  <= 32'h0;
				tmon_reg  <= 1'b1;
			end else if (tmon_reg && !t_done)
				tcnt_reg <= tcnt_reg + 32'h1;
			// Disabled mode stops time-delay supervision on modulation loss
			if (state_reg == ST_DECEL && !mod_reg) begin
				zcnt_reg <= 32'h0;
				if (mode_reg == `SLS_MODE_DISABLED)
					tmon_reg <= 1'b0;
			end else if (state_reg == ST_MODLOSS && !z_done)
				zcnt_reg <= zcnt_reg + 32'h1;
			if (state_next == ST_RESPOND && state_reg != ST_RESPOND) begin
				rcnt_reg       <= 32'h0;
				o_estop_active <= 1'b1;
				o_limit_hit    <= 1'b1;
				o_limited_speed_indication <= 1'b0;
			end else if (state_reg == ST_RESPOND)
				rcnt_reg <= rcnt_reg + 32'h1;
			if (state_next == ST_STOPPING && state_reg == ST_RESPOND) begin
				o_torque_off <= 1'b1;
				zcnt_reg     <= 32'h0;
			end else if (state_reg == ST_STOPPING && !z_done)
				zcnt_reg <= zcnt_reg + 32'h1;
			if (state_next == ST_STOPPED && state_reg == ST_STOPPING) begin
				o_estop_done <= 1'b1;
				o_limited_speed_indication <= 1'b1;
			end
			if (state_next == ST_MONITOR && state_reg != ST_MONITOR)
				o_limited_speed_indication <= 1'b1;
			if (state_reg == ST_MONITOR && at_trip)
				o_limited_speed_indication <= 1'b0;
			// One acknowledge clears both functions
			if (state_next == ST_IDLE && (state_reg == ST_MONITOR || state_reg == ST_STOPPED)) begin
				o_limited_speed_indication <= 1'b0;
				o_estop_active <= 1'b0;
				o_estop_done   <= 1'b0;
				o_torque_off   <= 1'b0;
				tmon_reg       <= 1'b0;
			end
		end
	end

	// Register writes
	// Mode and brake bits take effect when the next request is accepted; the boot hold reads the mode bits directly
	always @(posedge i_core_clk) begin
		if (i_rst) begin
			ctrl_reg   <= `SLS_CTRL_RST;
			trip_reg   <= `SLS_TRIP_RST;
			limit_reg  <= `SLS_LIMIT_RST;
			tdelay_reg <= `SLS_TDELAY_RST;
			zdelay_reg <= `SLS_ZDELAY_RST;
			bdelay_reg <= `SLS_BDELAY_RST;
			resp_reg   <= `SLS_RESP_RST;
		end else if (i_wr) begin
			case (i_addr)
				`SLS_ADDR_CTRL:   ctrl_reg   <= i_wdata[3:0];
				`SLS_ADDR_TRIP:   trip_reg   <= i_wdata[15:0];
				`SLS_ADDR_LIMIT:  limit_reg  <= i_wdata[15:0];
				`SLS_ADDR_TDELAY: tdelay_reg <= i_wdata;
				`SLS_ADDR_ZDELAY: zdelay_reg <= i_wdata;
				`SLS_ADDR_BDELAY: bdelay_reg <= i_wdata;
				`SLS_ADDR_RESP:   resp_reg   <= i_wdata;
				default: ;
			endcase
		end
	end

	// Register reads, one cycle late; unmapped and idle reads give zero
	always @(posedge i_core_clk) begin
		if (i_rst)
			o_rdata <= 32'h0;
		else if (i_rd) begin
			case (i_addr)
				`SLS_ADDR_CTRL:   o_rdata <= {28'h0, ctrl_reg};
				`SLS_ADDR_TRIP:   o_rdata <= {16'h0, trip_reg};
				`SLS_ADDR_LIMIT:  o_rdata <= {16'h0, limit_reg};
				`SLS_ADDR_TDELAY: o_rdata <= tdelay_reg;
				`SLS_ADDR_ZDELAY: o_rdata <= zdelay_reg;
				`SLS_ADDR_BDELAY: o_rdata <= bdelay_reg;
				`SLS_ADDR_RESP:   o_rdata <= resp_reg;
				`SLS_ADDR_STATUS: o_rdata <= {21'h0, tmon_reg, mode_reg, o_estop_done, o_estop_active,
					o_torque_off, o_restart_block, o_limited_speed_indication, state_reg};
				`SLS_ADDR_SPEED:  o_rdata <= {16'h0, speed_reg};
				default:          o_rdata <= 32'h0;
			endcase
		end else
			o_rdata <= 32'h0;
	end
endmodule // sls_supervisor
`default_nettype wire

/* File: design/sls_regs.vh */
// Constants for the limited-speed supervisor: register offsets, modes, timing
`ifndef SLS_REGS_VH
`define SLS_REGS_VH
// Register offsets (byte addresses, one 32-bit word each)
`define SLS_ADDR_CTRL      8'h00
`define SLS_ADDR_TRIP      8'h04
`define SLS_ADDR_LIMIT     8'h08
`define SLS_ADDR_TDELAY    8'h0C
`define SLS_ADDR_ZDELAY    8'h10
`define SLS_ADDR_BDELAY    8'h14
`define SLS_ADDR_RESP      8'h18
`define SLS_ADDR_STATUS    8'h1C
`define SLS_ADDR_SPEED     8'h20
// Control register fields
`define SLS_CTRL_MODE_LO   0
`define SLS_CTRL_MODE_HI   1
`define SLS_CTRL_BRAKE     2
`define SLS_CTRL_EST       3
// Modulation-loss behaviour codes
`define SLS_MODE_MONITOR   2'h0
`define SLS_MODE_MODOFF    2'h1
`define SLS_MODE_DISABLED  2'h2
// Reset values
`define SLS_CTRL_RST       4'h8
`define SLS_TRIP_RST       16'h0800
`define SLS_LIMIT_RST      16'h0600
`define SLS_TDELAY_RST     32'h0000_1000
`define SLS_ZDELAY_RST     32'h0000_1000
`define SLS_BDELAY_RST     32'h0000_1000
`define SLS_RESP_RST       32'h0000_0004
// Speed value assumed before valid data exists
`define SLS_SPEED_INIT     16'hFFFF
// Edges a pin needs through the synchroniser before boot trusts its level
`define SLS_SYNC_SETTLE    3'h4
`endif

/* File: testbench/sls_drive_model.sv */
// Drive model: own ramp, modulation state, torque-off response
`default_nettype none
module sls_drive_model (
	input  wire logic        i_core_clk,
	input  wire logic        i_mod_en,
	input  wire logic        i_torque_off,
	input  wire logic        i_load,
	input  wire logic [15:0] i_load_val,
	output logic             o_modulating,
	output logic [15:0]      o_speed,
	output logic             o_speed_valid
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] TARGET = 16'h0580;
	// Torque-off stops modulation at once
	assign o_modulating = i_mod_en && !i_torque_off;
	initial o_speed = 16'h0000;
	initial o_speed_valid = 1'b0;
	// Own ramp to target, paused while not modulating
	always @(posedge i_core_clk) begin
		if (i_load) begin
			o_speed <= i_load_val;
			o_speed_valid <= 1'b1;
		end else if (i_torque_off && o_speed > 16'h0003)
			o_speed <= o_speed - 16'h0004; // Coasting
		else if (o_modulating && o_speed > TARGET)
			o_speed <= o_speed - 16'h0004;
	end
endmodule // sls_drive_model
`default_nettype wire

/* File: testbench/sls_supervisor_sva.sv */
// Port checker for the limited-speed supervisor
`default_nettype none
module sls_supervisor_sva (
	input wire logic        i_core_clk,
	input wire logic        i_rst,
	input wire logic        i_rd,
	input wire logic        i_ack,
	input wire logic        i_request,
	input wire logic [31:0] o_rdata,
	input wire logic        o_torque_off,
	input wire logic        o_restart_block,
	input wire logic        o_limited_speed_indication,
	input wire logic        o_estop_active,
	input wire logic        o_estop_done,
	input wire logic        o_limit_hit,
	input wire logic        o_ack_refused
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	rdata_slot_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0) else $error("rdata off slot");
	hit_pulse_a: assert property (o_limit_hit |=> !o_limit_hit) else $error("hit not a pulse");
	refuse_pulse_a: assert property (o_ack_refused |=> !o_ack_refused) else $error("refuse long");
	refuse_blocked_a: assert property (o_ack_refused |-> o_restart_block) else $error("refuse free");
	hit_estop_a: assert property (o_limit_hit |-> ##[0:2] o_estop_active) else $error("no estop");
	hit_ind_off_a: assert property (o_limit_hit |-> ##[0:2] !o_limited_speed_indication) else $error("ind");
	// Torque-off waits out the response time, then follows
	resp_wait_a: assert property (o_limit_hit |-> !o_torque_off [*3] ##[0:5] o_torque_off)
		else $error("torque-off timing");
	torque_cause_a: assert property ($rose(o_torque_off) |-> o_estop_active) else $error("stray torque");
	done_ind_a: assert property ($rose(o_estop_done) |-> ##[0:1] o_limited_speed_indication)
		else $error("done without ind");
	// One acknowledge clears the whole stop
	ack_clear_a: assert property ($rose(i_ack) && o_estop_done && !i_request |-> ##[1:8]
		!(o_estop_active || o_estop_done || o_torque_off)) else $error("ack left stop");
endmodule // sls_supervisor_sva
bind sls_supervisor sls_supervisor_sva u_chk (.i_core_clk, .i_rst, .i_rd, .i_ack, .i_request, .o_rdata,
	.o_torque_off, .o_restart_block, .o_limited_speed_indication, .o_estop_active, .o_estop_done,
	.o_limit_hit, .o_ack_refused);
`default_nettype wire

/* File: testbench/tb_sls_supervisor.sv */
// Self-checking bench for the limited-speed supervisor
`default_nettype none
module tb_sls_supervisor;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_core_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_request = 1'b1, i_ack = 1'b0;
	logic mod_en = 1'b1, ld = 1'b0, refused, i_modulating, i_speed_valid;
	logic o_torque_off, o_restart_block, o_limited_speed_indication, o_estop_active, o_estop_done;
	logic o_limit_hit, o_ack_refused;
	logic [7:0]  i_addr = 8'h00;
	logic [15:0] i_speed, ld_val = 16'h0000;
	logic [31:0] i_wdata = 32'h0, o_rdata, rd_val;
	logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h24};
	logic [31:0] rv [8] = '{32'h8, 32'h800, 32'h600, 32'h1000, 32'h1000, 32'h1000, 32'h4, 32'h0};
	int num_errors = 0, n_compared = 0, n, m, hits = 0, h0;
	sls_supervisor dut (.i_core_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .i_request, .i_ack,
		.i_modulating, .i_speed, .i_speed_valid, .o_rdata, .o_torque_off, .o_restart_block,
		.o_limited_speed_indication, .o_estop_active, .o_estop_done, .o_limit_hit, .o_ack_refused);
	sls_drive_model u_drive (.i_core_clk, .i_mod_en(mod_en), .i_torque_off(o_torque_off), .i_load(ld),
		.i_load_val(ld_val), .o_modulating(i_modulating), .o_speed(i_speed), .o_speed_valid(i_speed_valid));
	always #20 i_core_clk = ~i_core_clk;
	// Hit pulses can come while the bench is busy, so count them
	always @(posedge i_core_clk) if (o_limit_hit === 1'b1) hits++;
	task automatic tick();
		@(posedge i_core_clk);
		#1;
	endtask
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge i_core_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(logic [7:0] a);
		@(posedge i_core_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1;
		rd_val = o_rdata;
	endtask
	task automatic load(logic [15:0] v);
		@(posedge i_core_clk);
		ld_val <= v;
		ld <= 1'b1;
		@(posedge i_core_clk);
		ld <= 1'b0;
		#1;
	endtask
	// Acknowledge pin held long enough to pass the synchroniser
	task automatic ack();
		@(posedge i_core_clk);
		i_ack <= 1'b1;
		refused = 1'b0;
		repeat (10) begin
			tick();
			if (o_ack_refused === 1'b1) refused = 1'b1;
		end
		@(posedge i_core_clk);
		i_ack <= 1'b0;
		repeat (6) tick();
	endtask
	task automatic req(logic v);
		@(posedge i_core_clk);
		i_request <= v;
		repeat (10) tick();
	endtask
	// Trip from monitoring; completion timed by brake or zero-speed delay
	task automatic trip(logic brk);
		wr(8'h00, brk ? 32'hC : 32'h8);
		req(1'b1);
		chk("ind on request", 1, o_limited_speed_indication);
		load(16'h0900);
		for (n = 0; n < 20 && o_limit_hit !== 1'b1; n++) tick();
		chk("limit hit", 1, o_limit_hit);
		repeat (2) tick();
		chk("trip state", 32'h2, {o_estop_active, o_limited_speed_indication});
		for (n = 0; n < 20 && o_torque_off !== 1'b1; n++) tick();
		chk("torque off", 1, o_torque_off);
		for (n = 0; n < 200 && o_estop_done !== 1'b1; n++) tick();
		chk("stop delay", 1, brk ? (n > 70 && n < 90) : (n > 24 && n < 40));
		rd(8'h1C);
		chk("stop status", 32'h4EF, rd_val);
		req(1'b0);
		chk("monitor held", 1, o_limited_speed_indication);
		ack();
		chk("cleared", 0, {o_estop_active, o_estop_done, o_torque_off, o_limited_speed_indication});
	endtask
	task automatic final_report();
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#(40 * 20000);
		num_errors++;
		final_report();
	end
	initial begin
		repeat (20) @(posedge i_core_clk);
		i_rst <= 1'b0;
		for (m = 0; m < 8; m++) begin
			rd(ra[m]);
			chk("reset value", rv[m], rd_val);
		end
		wr(8'h24, 32'hFF);
		rd(8'h24);
		chk("unmapped", 0, rd_val);
		rd(8'h20);
		chk("boot speed", 32'hFFFF, rd_val);
		load(16'h0400);
		chk("restart block", 1, o_restart_block);
		// Acknowledge before the short stop time is set, so the refusal is certain
		ack();
		chk("early ack", 1, refused);
		wr(8'h10, 32'h1E);
		wr(8'h14, 32'h50);
		// The count restarted at the refusal, so expiry lands about 30 cycles after it
		for (n = 0; n < 200 && o_limited_speed_indication !== 1'b1; n++) tick();
		chk("delay restart", 1, n > 10 && n < 20);
		chk("block at expiry", 1, o_restart_block);
		ack();
		chk("restart free", 0, {refused, o_restart_block});
		req(1'b0);
		ack();
		trip(1'b0);
		trip(1'b1);
		// Late modulation return: monitor and modoff modes trip, disabled mode does not
		wr(8'h0C, 32'h10);
		for (m = 0; m < 3; m++) begin
			wr(8'h00, m == 1 ? 32'hA : (m ? 32'h9 : 32'h8));
			load(16'h0A00);
			h0 = hits;
			@(posedge i_core_clk);
			i_request <= 1'b1;
			repeat (6) tick();
			@(posedge i_core_clk);
			mod_en <= 1'b0;
			repeat (20) tick();
			@(posedge i_core_clk);
			mod_en <= 1'b1;
			for (n = 0; n < 300 && o_limited_speed_indication !== 1'b1; n++) tick();
			chk("late return hit", m == 1 ? 0 : 1, hits != h0);
			if (m == 1) chk("midpoint", 1, i_speed <= 16'h0700);
			req(1'b0);
			ack();
		end
		final_report();
	end
endmodule // tb_sls_supervisor
`default_nettype wire
